/* ssa_pkg.sv */
// Shared constants for the status register access link
package ssa_pkg;
  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_ONE    = 8'h05;
  localparam logic [7:0] OP_READ_TWO    = 8'h35;
  localparam logic [7:0] OP_READ_THREE  = 8'h15;
  localparam logic [7:0] OP_READ_INDIR  = 8'h65;
  localparam logic [7:0] OP_WRITE_ONE   = 8'h01;
  localparam logic [7:0] OP_WRITE_TWO   = 8'h31;
  localparam logic [7:0] OP_WRITE_THREE = 8'h11;
  localparam logic [7:0] OP_WREN        = 8'h06;
  localparam logic [7:0] OP_WREN_VOL    = 8'h50;
  // ----------------------------------------------------------------
  // Status byte addresses and layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STAT_ONE   = 8'h01;
  localparam logic [7:0] ADDR_STAT_TWO   = 8'h02;
  localparam logic [7:0] ADDR_STAT_THREE = 8'h03;
  localparam logic [7:0] ADDR_STAT_LAST  = 8'h05;
  localparam logic [7:0] UNDEF_DATA      = 8'h00;
  localparam int         WEL_BIT         = 1;
  localparam logic [7:0] RST_STAT_ONE    = 8'h00;
  localparam logic [7:0] RST_STAT_TWO    = 8'h00;
  localparam logic [7:0] RST_STAT_THREE  = 8'h00;
  localparam logic [7:0] RST_STAT_FOUR   = 8'h00;
  localparam logic [7:0] RST_STAT_FIVE   = 8'h00;
  // ----------------------------------------------------------------
  // Host controller registers (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] HREG_CTRL   = 4'h0;
  localparam logic [3:0] HREG_TXDATA = 4'h4;
  localparam logic [3:0] HREG_RXDATA = 4'h8;
  localparam logic [3:0] HREG_STATUS = 4'hc;
  localparam int         CTRL_TX_LSB = 0;
  localparam int         CTRL_RX_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCK_HALF_NS   = 200;
  localparam int SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;
endpackage

/* ssa_link_if.sv */
// Serial link between host controller and status register device
`timescale 1ns/1ps
interface ssa_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (
    input  cs_n,
    input  sck,
    input  si,
    output so,
    output so_oe
  );
  modport host (
    output cs_n,
    output sck,
    output si,
    input  so,
    input  so_oe
  );
endinterface

/* ssa_flash_end.sv */
// Device end: status register read and write command interpreter
// Functional notes
// - 05h/35h/15h read status bytes one-three
// - Opcode is eight clocks, MSB first
// - Direct read: opcode then data, no address
// - Chip-select release ends read, output floats
// - 65h: opcode, address in; data out
// - One 8-bit address byte after 65h
// - Dummy byte on clocks 16-23
// - Addresses 01h-05h map status bytes one-five
// - Data from clock 24, MSB first
// - Address auto-increments after each byte
// - Host chooses read length by release
// - Unimplemented addresses give undefined bytes
// - Address wraps FFh to 00h
// - 01h/31h/11h write status bytes one-three
// - Write: opcode and data in, nothing out
// - 50h arms next write, latch unchanged
// - 06h sets latch before non-volatile write
// - Release after write clears the latch
// - Partial-byte release aborts the write
// - 01h second data byte writes byte two
`timescale 1ns/1ps
module ssa_flash_end (
  input  wire logic        clock,
  input  wire logic        rst_n,
  ssa_link_if.dev          link,
  output logic [39:0]      status_word,
  output logic             write_enable_latch
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic       cs_s1, cs_s2, cs_d;
  logic       sck_s1, sck_s2, sck_d;
  logic       si_s1, si_s2;
  logic       rise, fall, cs_end;
  logic [7:0] stat [1:5];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d  <= 1'b0;
      si_s1  <= 1'b0;
      si_s2  <= 1'b0;
    end else begin
      cs_s1  <= link.cs_n;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      sck_s1 <= link.sck;
      sck_s2 <= sck_s1;
      sck_d  <= sck_s2;
      si_s1  <= link.si;
      si_s2  <= si_s1;
    end
  end

  assign rise   = sck_s2 & ~sck_d & ~cs_s2;
  assign fall   = ~sck_s2 & sck_d & ~cs_s2;
  assign cs_end = cs_s2 & ~cs_d;

  // ----------------------------------------------------------------
  // Bit and byte framing
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] in_sr;
  logic [7:0] next_byte;
  logic       byte_done;
  logic [7:0] opcode;

  assign next_byte = {in_sr[6:0], si_s2};
  assign byte_done = rise & (bit_cnt == 3'h7);

  always_ff @(posedge clock) begin
    if (!rst_n || cs_s2) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      in_sr    <= 8'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sr   <= next_byte;
      if (byte_done && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      opcode <= 8'h00;
    end else if (byte_done && byte_cnt == 3'h0) begin
      opcode <= next_byte;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] direct_addr(input logic [7:0] op);
    logic [7:0] a;
    a = 8'h00;
    unique case (op)
      ssa_pkg::OP_READ_ONE,
      ssa_pkg::OP_WRITE_ONE:   a = ssa_pkg::ADDR_STAT_ONE;
      ssa_pkg::OP_READ_TWO,
      ssa_pkg::OP_WRITE_TWO:   a = ssa_pkg::ADDR_STAT_TWO;
      ssa_pkg::OP_READ_THREE,
      ssa_pkg::OP_WRITE_THREE: a = ssa_pkg::ADDR_STAT_THREE;
      default:                 a = 8'h00;
    endcase
    return a;
  endfunction

  function automatic logic is_dread(input logic [7:0] op);
    return op == ssa_pkg::OP_READ_ONE || op == ssa_pkg::OP_READ_TWO ||
           op == ssa_pkg::OP_READ_THREE;
  endfunction

  function automatic logic is_dwrite(input logic [7:0] op);
    return op == ssa_pkg::OP_WRITE_ONE || op == ssa_pkg::OP_WRITE_TWO ||
           op == ssa_pkg::OP_WRITE_THREE;
  endfunction

  function automatic logic [7:0] reg_data(input logic [7:0] a,
                                          input logic [39:0] w);
    logic [7:0] d;
    d = ssa_pkg::UNDEF_DATA;
    if (a >= ssa_pkg::ADDR_STAT_ONE && a <= ssa_pkg::ADDR_STAT_LAST) begin
      d = w[(3'(a - 8'h01))*8 +: 8];
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic       rd_act;
  logic       rd_indir;
  logic [7:0] rd_addr;
  logic [7:0] out_sr;
  logic [39:0] word;

  assign word = {stat[5], stat[4], stat[3], stat[2], stat[1]};

  always_ff @(posedge clock) begin
    if (!rst_n || cs_s2) begin
      rd_act   <= 1'b0;
      rd_indir <= 1'b0;
      rd_addr  <= 8'h00;
      out_sr   <= 8'h00;
    end else if (byte_done) begin
      if (byte_cnt == 3'h0 && is_dread(next_byte)) begin
        rd_act  <= 1'b1;
        rd_addr <= direct_addr(next_byte);
        out_sr  <= reg_data(direct_addr(next_byte), word);
      end else if (byte_cnt == 3'h0 &&
                   next_byte == ssa_pkg::OP_READ_INDIR) begin
        rd_indir <= 1'b1;
      end else if (rd_indir && byte_cnt == 3'h1) begin
        rd_addr <= next_byte;
      end else if (rd_indir && byte_cnt == 3'h2) begin
        rd_act  <= 1'b1;
        out_sr  <= reg_data(rd_addr, word);
        rd_addr <= rd_addr + 8'h01;
      end else if (rd_act && rd_indir) begin
        out_sr  <= reg_data(rd_addr, word);
        rd_addr <= rd_addr + 8'h01;
      end else if (rd_act) begin
        out_sr <= reg_data(rd_addr, word);
      end
    end else if (fall && rd_act) begin
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Output pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n || cs_s2) begin
      link.so    <= 1'b0;
      link.so_oe <= 1'b0;
    end else if (fall && rd_act) begin
      link.so    <= out_sr[7];
      link.so_oe <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Write data capture
  // ----------------------------------------------------------------
  logic [7:0] wdat_a;
  logic [7:0] wdat_b;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wdat_a <= 8'h00;
      wdat_b <= 8'h00;
    end else if (byte_done && byte_cnt == 3'h1) begin
      wdat_a <= next_byte;
    end else if (byte_done && byte_cnt == 3'h2) begin
      wdat_b <= next_byte;
    end
  end

  // ----------------------------------------------------------------
  // Write enables and status registers
  // ----------------------------------------------------------------
  logic vol_arm;
  logic whole;
  logic wr_ok;
  logic [7:0] wr_idx;

  assign whole  = bit_cnt == 3'h0 && byte_cnt != 3'h0;
  assign wr_ok  = cs_end && whole && is_dwrite(opcode) &&
                  byte_cnt >= 3'h2 &&
                  (stat[1][ssa_pkg::WEL_BIT] || vol_arm);
  assign wr_idx = direct_addr(opcode);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vol_arm <= 1'b0;
    end else if (cs_end && whole) begin
      vol_arm <= (opcode == ssa_pkg::OP_WREN_VOL) && byte_cnt == 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat[1] <= ssa_pkg::RST_STAT_ONE;
      stat[2] <= ssa_pkg::RST_STAT_TWO;
      stat[3] <= ssa_pkg::RST_STAT_THREE;
      stat[4] <= ssa_pkg::RST_STAT_FOUR;
      stat[5] <= ssa_pkg::RST_STAT_FIVE;
    end else if (cs_end) begin
      if (wr_ok) begin
        stat[wr_idx[2:0]] <= wdat_a;
        if (opcode == ssa_pkg::OP_WRITE_ONE && byte_cnt >= 3'h3) begin
          stat[2] <= wdat_b;
        end
      end
      if (is_dwrite(opcode)) begin
        stat[1][ssa_pkg::WEL_BIT] <= 1'b0;
      end else if (opcode == ssa_pkg::OP_WREN && whole &&
                   byte_cnt == 3'h1) begin
        stat[1][ssa_pkg::WEL_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // User view of the status bytes
  // ----------------------------------------------------------------
  assign status_word        = word;
  assign write_enable_latch = stat[1][ssa_pkg::WEL_BIT];
endmodule

/* ssa_host_end.sv */
// Host end: SPI controller with AXI4-Lite command registers
`timescale 1ns/1ps
module ssa_host_end (
  input  wire logic        clock,
  input  wire logic        rst_n,
  ssa_link_if.host         link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  typedef enum logic [3:0] {
    SSA_IDLE = 4'b0001,
    SSA_XFER = 4'b0010,
    SSA_END  = 4'b0100,
    SSA_GAP  = 4'b1000
  } ssa_state_t;

  ssa_state_t  state;
  logic [31:0] txdata;
  logic [31:0] rx_sr;
  logic [31:0] tx_sr;
  logic [2:0]  tx_cnt;
  logic [2:0]  rx_cnt;
  logic [6:0]  bits;
  logic [6:0]  total;
  logic [3:0]  div;
  logic        tick;
  logic        so_s1, so_s2;
  logic        start;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign start = awready && awaddr == ssa_pkg::HREG_CTRL &&
                 wstrb[0] && state == SSA_IDLE;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= ssa_pkg::RESP_OKAY;
    end else begin
      awready <= awvalid & wvalid & ~awready & ~bvalid;
      wready  <= awvalid & wvalid & ~awready & ~bvalid;
      if (awready) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr == ssa_pkg::HREG_CTRL ||
                   awaddr == ssa_pkg::HREG_TXDATA) ?
                  ssa_pkg::RESP_OKAY : ssa_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txdata <= 32'h0000_0000;
      tx_cnt <= 3'h0;
      rx_cnt <= 3'h0;
    end else if (awready && awaddr == ssa_pkg::HREG_TXDATA) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb[i]) begin
          txdata[i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
    end else if (start) begin
      tx_cnt <= wdata[ssa_pkg::CTRL_TX_LSB +: 3];
      rx_cnt <= wdata[ssa_pkg::CTRL_RX_LSB +: 3];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ssa_pkg::RESP_OKAY;
    end else begin
      arready <= arvalid & ~arready & ~rvalid;
      if (arready) begin
        rvalid <= 1'b1;
        rresp  <= ssa_pkg::RESP_OKAY;
        unique case (araddr)
          ssa_pkg::HREG_CTRL:   rdata <= {21'h0, rx_cnt, 5'h0, tx_cnt};
          ssa_pkg::HREG_TXDATA: rdata <= txdata;
          ssa_pkg::HREG_RXDATA: rdata <= rx_sr;
          ssa_pkg::HREG_STATUS: rdata <= {31'h0, state != SSA_IDLE};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= ssa_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial clock divider and link sequencer
  // ----------------------------------------------------------------
  assign tick = div == 4'(ssa_pkg::SCK_HALF_CYC - 1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      so_s1 <= 1'b0;
      so_s2 <= 1'b0;
    end else begin
      so_s1 <= link.so;
      so_s2 <= so_s1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || state == SSA_IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state     <= SSA_IDLE;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.si   <= 1'b0;
      tx_sr     <= 32'h0000_0000;
      rx_sr     <= 32'h0000_0000;
      bits      <= 7'h00;
      total     <= 7'h00;
    end else begin
      unique case (state)
        SSA_IDLE: if (start) begin
          state     <= SSA_XFER;
          link.cs_n <= 1'b0;
          tx_sr     <= {txdata[7:0], txdata[15:8],
                        txdata[23:16], txdata[31:24]};
          link.si   <= txdata[7];
          bits      <= 7'h00;
          total     <= {4'(wdata[ssa_pkg::CTRL_TX_LSB +: 3]) +
                        4'(wdata[ssa_pkg::CTRL_RX_LSB +: 3]), 3'h0};
        end
        SSA_XFER: if (tick) begin
          link.sck <= ~link.sck;
          if (!link.sck) begin
            rx_sr <= {rx_sr[30:0], so_s2};
            bits  <= bits + 7'h01;
          end else if (bits == total) begin
            state <= SSA_END;
          end else begin
            tx_sr   <= {tx_sr[30:0], 1'b0};
            link.si <= tx_sr[30];
          end
        end
        SSA_END: if (tick) begin
          state     <= SSA_GAP;
          link.cs_n <= 1'b1;
          link.si   <= 1'b0;
        end
        SSA_GAP: if (tick) begin
          state <= SSA_IDLE;
        end
      endcase
    end
  end
endmodule

/* ssa_link_checker.sv */
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
module ssa_link_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] bits;
  logic [3:0] idle;
  logic       sck_q;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    sck_q <= rst_n ? sck : 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || cs_n) begin
      bits <= 8'h00;
    end else if (sck && !sck_q) begin
      bits <= bits + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || !cs_n) begin
      idle <= 4'h0;
    end else if (idle != 4'hf) begin
      idle <= idle + 4'h1;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_float_after_release: assert property (
    $rose(cs_n) |-> ##[1:6] !so_oe) else $error("Output not floated");
  a_no_drive_idle: assert property (
    idle >= 4'h6 |-> !so_oe) else $error("Output driven while idle");
  a_oe_holds_frame: assert property (
    $fell(so_oe) |-> cs_n && $past(cs_n)) else $error("Output dropped early");
  a_oe_only_selected: assert property (
    $rose(so_oe) |-> !cs_n) else $error("Output enabled while deselected");
  a_oe_after_opcode: assert property (
    $rose(so_oe) |-> bits == 8'h08 || bits == 8'h18)
    else $error("Output enabled at wrong bit");
  a_oe_low_clock: assert property (
    $rose(so_oe) |-> !sck) else $error("Output enabled with clock high");
  a_sck_idle_low: assert property (
    cs_n && $past(cs_n) |-> !sck) else $error("Serial clock not idle low");
  a_si_settled: assert property (
    $rose(sck) |-> $stable(si)) else $error("Input line moved at rise");
  a_so_steady_high: assert property (
    !cs_n && sck && $past(sck) |-> $stable(so))
    else $error("Output line moved while clock high");
  a_whole_bytes: assert property (
    $rose(cs_n) |-> bits[2:0] == 3'h0 && bits != 8'h00)
    else $error("Frame not whole bytes");
  c_direct_read: cover property ($rose(so_oe) && bits == 8'h08);
  c_indirect_read: cover property ($rose(so_oe) && bits == 8'h18);
  c_long_frame: cover property ($rose(cs_n) && bits == 8'h38);
endmodule

/* ssa_bench.sv */
// Bench: host end drives the device end over the serial link
`timescale 1ns/1ps
module spi_status_register_access_bench;
  logic        clock;
  logic        rst_n;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [39:0] status_word;
  logic        write_enable_latch;
  int          n_errors;
  int          n_compared;
  ssa_link_if  link ();
  ssa_host_end i_ssa_host_end (
    .clock(clock), .rst_n(rst_n), .link(link),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  ssa_flash_end i_ssa_flash_end (
    .clock(clock), .rst_n(rst_n), .link(link),
    .status_word(status_word), .write_enable_latch(write_enable_latch));
  ssa_link_checker i_ssa_link_checker (
    .clock(clock), .rst_n(rst_n), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .so(link.so), .so_oe(link.so_oe));
  always #12.5 clock = ~clock;
  // ----------------------------------------------------------------
  // Bus and frame tasks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic frame(input logic [31:0] tx, input logic [2:0] ntx,
                       input logic [2:0] nrx, output logic [31:0] rx);
    logic [1:0]  r;
    logic [31:0] st;
    axi_wr(ssa_pkg::HREG_TXDATA, tx, r);
    axi_wr(ssa_pkg::HREG_CTRL, {21'h0, nrx, 5'h0, ntx}, r);
    check(r, ssa_pkg::RESP_OKAY);
    do axi_rd(ssa_pkg::HREG_STATUS, st, r); while (st[0] === 1'b1);
    axi_rd(ssa_pkg::HREG_RXDATA, rx, r);
  endtask
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rx;
    logic [1:0]  r;
    logic [7:0]  ops [3];
    logic [7:0]  vals [3];
    ops = '{ssa_pkg::OP_READ_ONE, ssa_pkg::OP_READ_TWO,
            ssa_pkg::OP_READ_THREE};
    vals = '{8'h11, 8'h22, 8'h33};
    clock = 1'b0;
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    n_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check(status_word, 40'h0);
    frame({24'h0, ssa_pkg::OP_WREN}, 3'h1, 3'h0, rx);
    check(write_enable_latch, 40'h1);
    frame({16'h0, 8'haa, ssa_pkg::OP_WRITE_ONE}, 3'h2, 3'h0, rx);
    check(status_word, 40'ha8);
    frame({16'h0, 8'h5a, ssa_pkg::OP_WRITE_TWO}, 3'h2, 3'h0, rx);
    check(status_word, 40'ha8);
    frame({24'h0, ssa_pkg::OP_WREN_VOL}, 3'h1, 3'h0, rx);
    check(write_enable_latch, 40'h0);
    frame({16'h0, 8'h5a, ssa_pkg::OP_WRITE_TWO}, 3'h2, 3'h0, rx);
    check(status_word, 40'h5aa8);
    frame({24'h0, ssa_pkg::OP_WREN_VOL}, 3'h1, 3'h0, rx);
    frame({24'h0, ssa_pkg::OP_READ_ONE}, 3'h1, 3'h1, rx);
    frame({16'h0, 8'h77, ssa_pkg::OP_WRITE_TWO}, 3'h2, 3'h0, rx);
    check(status_word, 40'h5aa8);
    frame({24'h0, ssa_pkg::OP_WREN}, 3'h1, 3'h0, rx);
    frame({8'h0, 8'h22, 8'h11, ssa_pkg::OP_WRITE_ONE}, 3'h3, 3'h0,
          rx);
    check(status_word, 40'h2211);
    frame({24'h0, ssa_pkg::OP_WREN}, 3'h1, 3'h0, rx);
    frame({16'h0, 8'h33, ssa_pkg::OP_WRITE_THREE}, 3'h2, 3'h0,
          rx);
    check(status_word, 40'h332211);
    for (int i = 0; i < 3; i++) begin
      frame({24'h0, ops[i]}, 3'h1, 3'h2, rx);
      check(rx[15:0], {vals[i], vals[i]});
    end
    frame({16'h01, ssa_pkg::OP_READ_INDIR}, 3'h3, 3'h4, rx);
    check(rx, 32'h11223300);
    frame({16'hfe, ssa_pkg::OP_READ_INDIR}, 3'h3, 3'h4, rx);
    check(rx, 32'h00000011);
    axi_wr(4'h2, 32'hffff_ffff, r);
    check(r, ssa_pkg::RESP_SLVERR);
    axi_rd(4'h2, rx, r);
    check(r, ssa_pkg::RESP_SLVERR);
    axi_rd(ssa_pkg::HREG_CTRL, rx, r);
    check(rx, 32'h0000_0403);
    check(r, ssa_pkg::RESP_OKAY);
    axi_rd(ssa_pkg::HREG_TXDATA, rx, r);
    check(rx, 32'h0000_fe65);
    check(status_word, 40'h332211);
    conclude();
  end
  initial begin
    #2000000;
    n_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end
endmodule
